// ### core/tcc_pkg.sv
// Constants, types and helper functions for the timer capture channel configuration block
// What this block does
// - Ch1 direction: 00 output, 01 input1, 10 input2
// - Ch1 direction 11 takes internal trigger source
// - Ch1 direction writable only while ch1 disabled
// - Prescaler captures every 1/2/4/8 events
// - Filter code 0000 samples raw, unfiltered
// - Filter codes map to divider/length pairs
// - Sample at clock/DIV, change after N samples
// - Ch2 direction: output, input1, input2, trigger
// - Ch2 direction writable only while ch2 disabled
// - Ch2 prescaler held in bits 11:10
// - Ch2 filter held in bits 15:12
// - Second mode register: 0x1C, reset zero, ch3/ch4
// - Ch3 direction: output, input3, input4, trigger
// - Ch4 direction: output, input4, input3, trigger
package tcc_pkg;

    localparam logic [7:0]  TCC_OFF_CFG_LO  = 8'h18;
    localparam logic [7:0]  TCC_OFF_CFG_HI  = 8'h1C;
    localparam logic [7:0]  TCC_OFF_ENABLE  = 8'h20;
    localparam logic [7:0]  TCC_OFF_STATUS  = 8'h24;

    localparam logic [15:0] TCC_CFG_RST     = 16'h0000;
    localparam logic [3:0]  TCC_ENABLE_RST  = 4'h0;

    // Channel byte layout inside a mode register
    localparam int          TCC_DIR_LSB     = 0;
    localparam int          TCC_PSC_LSB     = 2;
    localparam int          TCC_FLT_LSB     = 4;
    localparam int          TCC_ODD_CH_LSB  = 8;
    localparam int          TCC_STAT_DIR_LSB = 4;

    localparam logic [1:0]  TCC_DIR_OUTPUT  = 2'h0;
    localparam logic [1:0]  TCC_DIR_NEAR    = 2'h1;
    localparam logic [1:0]  TCC_DIR_FAR     = 2'h2;
    localparam logic [1:0]  TCC_DIR_TRIGGER = 2'h3;

    localparam logic [3:0]  TCC_FLT_BYPASS  = 4'h0;

    typedef struct packed {
        logic [3:0] flt;
        logic [1:0] psc;
        logic [1:0] dir;
    } tcc_chan_cfg_t;

    typedef struct packed {
        logic [2:0] div_log2;
        logic [3:0] len;
    } tcc_flt_sel_t;

    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } tcc_bus_req_t;

    function automatic tcc_flt_sel_t tcc_flt_decode(input logic [3:0] code);
        tcc_flt_sel_t sel;
        sel = '{div_log2: 3'h0, len: 4'h1};
        case (code)
            4'h1:    sel = '{div_log2: 3'h0, len: 4'h2};
            4'h2:    sel = '{div_log2: 3'h0, len: 4'h4};
            4'h3:    sel = '{div_log2: 3'h0, len: 4'h8};
            4'h4:    sel = '{div_log2: 3'h1, len: 4'h6};
            4'h5:    sel = '{div_log2: 3'h1, len: 4'h8};
            4'h6:    sel = '{div_log2: 3'h2, len: 4'h6};
            4'h7:    sel = '{div_log2: 3'h2, len: 4'h8};
            4'h8:    sel = '{div_log2: 3'h3, len: 4'h6};
            4'h9:    sel = '{div_log2: 3'h3, len: 4'h8};
            4'hA:    sel = '{div_log2: 3'h4, len: 4'h5};
            4'hB:    sel = '{div_log2: 3'h4, len: 4'h6};
            4'hC:    sel = '{div_log2: 3'h4, len: 4'h8};
            4'hD:    sel = '{div_log2: 3'h5, len: 4'h5};
            4'hE:    sel = '{div_log2: 3'h5, len: 4'h6};
            4'hF:    sel = '{div_log2: 3'h5, len: 4'h8};
            default: sel = '{div_log2: 3'h0, len: 4'h1};
        endcase
        return sel;
    endfunction : tcc_flt_decode

    // Last count before a capture: ratio 1/2/4/8 minus one
    function automatic logic [2:0] tcc_psc_last(input logic [1:0] psc);
        return 3'((4'h1 << psc) - 4'h1);
    endfunction : tcc_psc_last

    function automatic logic tcc_chan_source(input logic [1:0] dir,
                                             input logic       near_pin,
                                             input logic       far_pin,
                                             input logic       trg,
                                             input logic       trg_ok);
        logic src;
        src = 1'b0;
        case (dir)
            TCC_DIR_NEAR:    src = near_pin;
            TCC_DIR_FAR:     src = far_pin;
            TCC_DIR_TRIGGER: src = trg & trg_ok;
            default:         src = 1'b0;
        endcase
        return src;
    endfunction : tcc_chan_source

endpackage : tcc_pkg

// ### core/tcc_filter.sv
// Digital input filter for one capture channel
`timescale 1ns/100ps
module tcc_filter (
    input  wire logic       mclk_i,
    input  wire logic       resetn_i,
    input  wire logic       raw_i,
    input  wire logic [3:0] code_i,
    output logic            level_o
);
    import tcc_pkg::*;

    tcc_flt_sel_t sel;
    logic [4:0]   div_cnt_reg;
    logic [3:0]   run_cnt_reg;
    logic         level_reg;
    logic         tick;
    logic         bypass;

    assign sel     = tcc_flt_decode(code_i);
    assign bypass  = (code_i == TCC_FLT_BYPASS);
    assign tick    = bypass || (div_cnt_reg == 5'((6'h1 << sel.div_log2) - 6'h1));
    assign level_o = level_reg;

    always_ff @(posedge mclk_i) begin
        if (!resetn_i || tick) begin
            div_cnt_reg <= 5'h0;
        end else begin
            div_cnt_reg <= div_cnt_reg + 5'h1;
        end
    end

    // Count runs of samples that disagree with the present level
    always_ff @(posedge mclk_i) begin
        if (!resetn_i) begin
            run_cnt_reg <= 4'h0;
            level_reg   <= 1'b0;
        end else if (bypass) begin
            run_cnt_reg <= 4'h0;
            level_reg   <= raw_i;
        end else if (tick) begin
            if (raw_i == level_reg) begin
                run_cnt_reg <= 4'h0;
            end else if (run_cnt_reg + 4'h1 >= sel.len) begin
                run_cnt_reg <= 4'h0;
                level_reg   <= raw_i;
            end else begin
                run_cnt_reg <= run_cnt_reg + 4'h1;
            end
        end
    end

    chk_flt_bypass_follow: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        bypass |=> level_reg == $past(raw_i))
        else $error("Unfiltered channel did not follow its input");

    chk_flt_change_on_tick: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        ($changed(level_reg) && !$past(bypass)) |-> $past(tick) && $past(run_cnt_reg) == $past(sel.len) - 4'h1)
        else $error("Filtered level changed without N agreeing samples");

endmodule : tcc_filter

// ### core/tcc_prescaler.sv
// Capture event prescaler for one channel
`timescale 1ns/100ps
module tcc_prescaler (
    input  wire logic       mclk_i,
    input  wire logic       resetn_i,
    input  wire logic       clear_i,
    input  wire logic       event_i,
    input  wire logic [1:0] psc_i,
    output logic            capture_o
);
    import tcc_pkg::*;

    logic [2:0] cnt_reg;
    logic       capture_reg;

    assign capture_o = capture_reg;

    always_ff @(posedge mclk_i) begin
        if (!resetn_i || clear_i) begin
            cnt_reg     <= 3'h0;
            capture_reg <= 1'b0;
        end else if (event_i) begin
            capture_reg <= (cnt_reg >= tcc_psc_last(psc_i));
            cnt_reg     <= (cnt_reg >= tcc_psc_last(psc_i)) ? 3'h0 : cnt_reg + 3'h1;
        end else begin
            capture_reg <= 1'b0;
        end
    end

    sequence s_last_event;
        event_i && !clear_i && cnt_reg >= tcc_psc_last(psc_i);
    endsequence

    chk_psc_capture_due: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        s_last_event |=> capture_reg && cnt_reg == 3'h0)
        else $error("Prescaler missed a due capture");

    chk_psc_no_early: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        capture_reg |-> $past(event_i) && $past(cnt_reg) >= $past(tcc_psc_last(psc_i)))
        else $error("Prescaler captured early");

endmodule : tcc_prescaler

// ### core/tcc_top.sv
// Capture channel configuration: mode registers, input routing, filters and prescalers
`timescale 1ns/100ps
module tcc_top #(
    parameter int NUM_CH = 4
) (
    input  wire logic              mclk_i,
    input  wire logic              resetn_i,
    input  wire logic [7:0]        addr_i,
    input  wire logic [31:0]       wdata_i,
    input  wire logic              wr_i,
    input  wire logic              rd_i,
    output logic      [31:0]       rdata_o,
    input  wire logic              pin_input_one_i,
    input  wire logic              pin_input_two_i,
    input  wire logic              pin_input_three_i,
    input  wire logic              pin_input_four_i,
    input  wire logic              trigger_routing_source_i,
    input  wire logic              trigger_internal_i,
    output logic      [NUM_CH-1:0] capture_input_o,
    output logic      [NUM_CH-1:0] capture_event_o,
    output logic      [NUM_CH-1:0] channel_is_input_o
);
    import tcc_pkg::*;

    tcc_bus_req_t          req;
    logic [15:0]           capture_mode_config_lo_reg;
    logic [15:0]           capture_mode_config_hi_reg;
    logic [15:0]           cfg_lo_next;
    logic [15:0]           cfg_hi_next;
    logic [3:0]            channel_enable_reg;
    logic [31:0]           rdata_reg;
    logic [31:0]           rdata_next;
    tcc_chan_cfg_t         chan_cfg    [NUM_CH];
    logic [NUM_CH-1:0]     near_pin;
    logic [NUM_CH-1:0]     far_pin;
    logic [NUM_CH-1:0]     src_raw;
    logic [NUM_CH-1:0]     filt_level;
    logic [NUM_CH-1:0]     filt_level_d_reg;
    logic [NUM_CH-1:0]     qual_event;
    logic [NUM_CH-1:0]     psc_clear;
    logic [NUM_CH-1:0]     is_input;
    logic                  wr_lo;
    logic                  wr_hi;

    assign req     = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};
    assign wr_lo   = req.wr && (req.addr == TCC_OFF_CFG_LO);
    assign wr_hi   = req.wr && (req.addr == TCC_OFF_CFG_HI);
    assign rdata_o = rdata_reg;

    // A direction field only accepts a new value while its channel is off;
    // the other fields of the same byte take the write regardless.
    function automatic logic [7:0] tcc_merge_byte(input logic [7:0] old_b,
                                                  input logic [7:0] new_b,
                                                  input logic       locked);
        logic [7:0] res;
        res = new_b;
        if (locked) begin
            res[TCC_DIR_LSB+:2] = old_b[TCC_DIR_LSB+:2];
        end
        return res;
    endfunction : tcc_merge_byte

    always_comb begin
        cfg_lo_next = capture_mode_config_lo_reg;
        cfg_hi_next = capture_mode_config_hi_reg;
        if (wr_lo) begin
            cfg_lo_next[7:0]  = tcc_merge_byte(capture_mode_config_lo_reg[7:0],
                                               req.wdata[7:0], channel_enable_reg[0]);
            cfg_lo_next[15:8] = tcc_merge_byte(capture_mode_config_lo_reg[15:8],
                                               req.wdata[15:8], channel_enable_reg[1]);
        end
        if (wr_hi) begin
            cfg_hi_next[7:0]  = tcc_merge_byte(capture_mode_config_hi_reg[7:0],
                                               req.wdata[7:0], channel_enable_reg[2]);
            cfg_hi_next[15:8] = tcc_merge_byte(capture_mode_config_hi_reg[15:8],
                                               req.wdata[15:8], channel_enable_reg[3]);
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!resetn_i) begin
            capture_mode_config_lo_reg <= TCC_CFG_RST;
            capture_mode_config_hi_reg <= TCC_CFG_RST;
        end else begin
            capture_mode_config_lo_reg <= cfg_lo_next;
            capture_mode_config_hi_reg <= cfg_hi_next;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!resetn_i) begin
            channel_enable_reg <= TCC_ENABLE_RST;
        end else if (req.wr && (req.addr == TCC_OFF_ENABLE)) begin
            channel_enable_reg <= req.wdata[3:0];
        end
    end

    // Read data stands for exactly one cycle; unmapped offsets read zero
    always_comb begin
        rdata_next = 32'h0000_0000;
        if (req.rd) begin
            case (req.addr)
                TCC_OFF_CFG_LO: rdata_next = {16'h0000, capture_mode_config_lo_reg};
                TCC_OFF_CFG_HI: rdata_next = {16'h0000, capture_mode_config_hi_reg};
                TCC_OFF_ENABLE: rdata_next = {28'h0, channel_enable_reg};
                TCC_OFF_STATUS: rdata_next = {24'h0, 4'(is_input), 4'(filt_level)};
                default:        rdata_next = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!resetn_i) begin
            rdata_reg <= 32'h0000_0000;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    // Field layout: each channel is one byte; ch2 and ch4 sit in the upper byte
    assign chan_cfg[0] = tcc_chan_cfg_t'(capture_mode_config_lo_reg[7:0]);
    assign chan_cfg[1] = tcc_chan_cfg_t'(capture_mode_config_lo_reg[TCC_ODD_CH_LSB+:8]);
    assign chan_cfg[2] = tcc_chan_cfg_t'(capture_mode_config_hi_reg[7:0]);
    assign chan_cfg[3] = tcc_chan_cfg_t'(capture_mode_config_hi_reg[TCC_ODD_CH_LSB+:8]);

    // Ch1 and ch2 share the same pin pair in the same order
    assign near_pin = {pin_input_four_i, pin_input_three_i, pin_input_one_i, pin_input_one_i};
    assign far_pin  = {pin_input_three_i, pin_input_four_i, pin_input_two_i, pin_input_two_i};

    assign capture_input_o    = filt_level;
    assign channel_is_input_o = is_input;

    genvar ch;
    generate
        for (ch = 0; ch < NUM_CH; ch++) begin : g_chan
            // Trigger source outside internal trigger use reads as idle low
            assign src_raw[ch]  = tcc_chan_source(chan_cfg[ch].dir, near_pin[ch], far_pin[ch],
                                                  trigger_routing_source_i, trigger_internal_i);
            assign is_input[ch] = (chan_cfg[ch].dir != TCC_DIR_OUTPUT);

            tcc_filter u_filter (
                .mclk_i   (mclk_i),
                .resetn_i (resetn_i),
                .raw_i    (src_raw[ch]),
                .code_i   (chan_cfg[ch].flt),
                .level_o  (filt_level[ch])
            );

            // Rising edge of the filtered level is the qualifying event
            assign qual_event[ch] = filt_level[ch] && !filt_level_d_reg[ch]
                                    && is_input[ch] && channel_enable_reg[ch];
            // Restart the ratio count whenever the channel is off
            assign psc_clear[ch]  = !channel_enable_reg[ch] || !is_input[ch];

            tcc_prescaler u_prescaler (
                .mclk_i    (mclk_i),
                .resetn_i  (resetn_i),
                .clear_i   (psc_clear[ch]),
                .event_i   (qual_event[ch]),
                .psc_i     (chan_cfg[ch].psc),
                .capture_o (capture_event_o[ch])
            );
        end
    endgenerate

    always_ff @(posedge mclk_i) begin
        if (!resetn_i) begin
            filt_level_d_reg <= '0;
        end else begin
            filt_level_d_reg <= filt_level;
        end
    end

    sequence s_lo_write_ch1_locked;
        wr_lo && channel_enable_reg[0];
    endsequence

    sequence s_lo_write_ch2_locked;
        wr_lo && channel_enable_reg[1];
    endsequence

    sequence s_lo_write_ch1_open;
        wr_lo && !channel_enable_reg[0];
    endsequence

    chk_ch1_dir_lock: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        s_lo_write_ch1_locked |=> $stable(capture_mode_config_lo_reg[1:0]))
        else $error("Ch1 direction changed while enabled");

    chk_ch2_dir_lock: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        s_lo_write_ch2_locked |=> $stable(capture_mode_config_lo_reg[9:8]))
        else $error("Ch2 direction changed while enabled");

    chk_ch1_dir_write: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        s_lo_write_ch1_open |=> capture_mode_config_lo_reg[1:0] == $past(wdata_i[1:0]))
        else $error("Ch1 direction write lost while disabled");

    chk_ch2_fields_pos: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        wr_lo |=> capture_mode_config_lo_reg[15:10] == $past(wdata_i[15:10]))
        else $error("Ch2 prescaler or filter field not held in place");

    chk_hi_reset_zero: assert property (@(posedge mclk_i)
        !resetn_i |=> capture_mode_config_hi_reg == 16'h0000)
        else $error("Second mode register did not reset to zero");

    chk_ch1_route: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        chan_cfg[0].dir == TCC_DIR_FAR |-> src_raw[0] == pin_input_two_i)
        else $error("Ch1 far input routed wrongly");

    chk_ch1_trigger: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        (chan_cfg[0].dir == TCC_DIR_TRIGGER && trigger_internal_i) |-> src_raw[0] == trigger_routing_source_i)
        else $error("Ch1 trigger source not routed");

    chk_ch2_route: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        chan_cfg[1].dir == TCC_DIR_NEAR |-> src_raw[1] == pin_input_one_i)
        else $error("Ch2 near input routed wrongly");

    chk_ch3_route: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        chan_cfg[2].dir == TCC_DIR_FAR |-> src_raw[2] == pin_input_four_i)
        else $error("Ch3 far input routed wrongly");

    chk_ch4_route: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        chan_cfg[3].dir == TCC_DIR_FAR |-> src_raw[3] == pin_input_three_i)
        else $error("Ch4 far input routed wrongly");

    chk_read_one_cycle: assert property (@(posedge mclk_i) disable iff (!resetn_i)
        (rd_i && addr_i == TCC_OFF_CFG_HI) |=> rdata_o == {16'h0000, $past(capture_mode_config_hi_reg)})
        else $error("Read data of second mode register wrong");

endmodule : tcc_top

// ### dv/tcc_far_side_model.sv
// Far-side model: timer input pins and internal trigger source
`timescale 1ns/100ps
module tcc_far_side_model (
    input  wire logic       mclk_i,
    input  wire logic [4:0] level_req_i,
    input  wire logic [3:0] lag_i,
    output logic      [4:0] pins_o
);
    logic [4:0] hist_reg [16];

    // Whole pattern delayed together, so pulse widths survive a slow setting
    always_ff @(posedge mclk_i) begin
        hist_reg[0] <= level_req_i;
        for (int i = 1; i < 16; i++) begin
            hist_reg[i] <= hist_reg[i-1];
        end
    end

    assign pins_o = hist_reg[lag_i];
endmodule : tcc_far_side_model

// ### dv/timer_capture_channel_config_bench.sv
// Self-checking bench for the capture channel configuration block
`timescale 1ns/100ps
module timer_capture_channel_config_bench;
    import tcc_pkg::*;
    localparam int CYCLE_LIMIT = 20000;
    localparam int N_TAB   [16] = '{1, 2, 4, 8, 6, 8, 6, 8, 6, 8, 5, 6, 8, 5, 6, 8};
    localparam int DIV_TAB [16] = '{1, 1, 1, 1, 2, 2, 4, 4, 8, 8, 16, 16, 16, 32, 32, 32};
    localparam int NEAR_PIN [4] = '{0, 0, 2, 3};
    localparam int FAR_PIN  [4] = '{1, 1, 3, 2};

    logic        mclk_i;
    logic        resetn_i;
    logic [7:0]  addr_i;
    logic [31:0] wdata_i;
    logic        wr_i;
    logic        rd_i;
    logic [31:0] rdata_o;
    logic [4:0]  pin_req;
    logic [4:0]  pins;
    logic [3:0]  lag;
    logic        trig_int;
    logic [3:0]  capture_input_o;
    logic [3:0]  capture_event_o;
    logic [3:0]  channel_is_input_o;
    int          err_total;
    int          samples_checked;
    int          cycle_cnt;
    int          ev1_cnt;
    int          ev2_cnt;
    int          ev3_cnt;
    int          ev4_cnt;
    logic        counting;
    logic        watch_low;

    tcc_far_side_model far_side (.mclk_i(mclk_i), .level_req_i(pin_req), .lag_i(lag), .pins_o(pins));

    tcc_top #(.NUM_CH(4)) DUT (
        .mclk_i(mclk_i), .resetn_i(resetn_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
        .rdata_o(rdata_o), .pin_input_one_i(pins[0]), .pin_input_two_i(pins[1]),
        .pin_input_three_i(pins[2]), .pin_input_four_i(pins[3]), .trigger_routing_source_i(pins[4]),
        .trigger_internal_i(trig_int), .capture_input_o(capture_input_o),
        .capture_event_o(capture_event_o), .channel_is_input_o(channel_is_input_o)
    );

    initial begin
        mclk_i = 1'b0;
        forever #20 mclk_i = ~mclk_i;
    end

    task automatic end_sim();
        $display("checks %0d errors %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : end_sim

    always @(posedge mclk_i) begin
        cycle_cnt++;
        if (counting) begin
            ev1_cnt += int'(capture_event_o[0] === 1'b1);
            ev2_cnt += int'(capture_event_o[1] === 1'b1);
            ev3_cnt += int'(capture_event_o[2] === 1'b1);
            ev4_cnt += int'(capture_event_o[3] === 1'b1);
        end
        // Short pulses must never leak through the filter
        if (watch_low && capture_input_o[0] !== 1'b0) begin
            err_total++;
            $display("[ERR] %0t short pulse passed filter", $time);
        end
        if (cycle_cnt >= CYCLE_LIMIT) begin
            err_total++;
            $display("[ERR] %0t timeout", $time);
            end_sim();
        end
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : check

    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk_i);
        addr_i  <= a;
        wdata_i <= d;
        wr_i    <= 1'b1;
        @(posedge mclk_i);
        wr_i    <= 1'b0;
    endtask : reg_wr

    task automatic reg_chk(input logic [7:0] a, input logic [31:0] exp);
        @(posedge mclk_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge mclk_i);
        rd_i   <= 1'b0;
        #1;
        check(rdata_o, exp, "register read");
    endtask : reg_chk

    function automatic logic [3:0] route_exp(input logic [1:0] d, input logic [5:0] p);
        logic [3:0] r;
        for (int ch = 0; ch < 4; ch++) begin
            case (d)
                2'h1:    r[ch] = p[NEAR_PIN[ch]];
                2'h2:    r[ch] = p[FAR_PIN[ch]];
                2'h3:    r[ch] = p[4] & p[5];
                default: r[ch] = 1'b0;
            endcase
        end
        return r;
    endfunction : route_exp

    task automatic test_reset();
        reg_chk(TCC_OFF_CFG_LO, 32'h0000_0000);
        reg_chk(TCC_OFF_CFG_HI, 32'h0000_0000);
        reg_chk(TCC_OFF_ENABLE, 32'h0000_0000);
        reg_wr(TCC_OFF_CFG_HI, 32'h0000_FFFF);
        reg_chk(TCC_OFF_CFG_HI, 32'h0000_FFFF);
        reg_wr(8'h30, 32'h0000_FFFF);
        reg_chk(8'h30, 32'h0000_0000);
        reg_wr(TCC_OFF_CFG_HI, 32'h0000_0000);
    endtask : test_reset

    task automatic test_routing();
        logic [5:0] p;
        for (int d = 0; d < 4; d++) begin
            reg_wr(TCC_OFF_CFG_LO, {22'h0, 2'(d), 6'h0, 2'(d)});
            reg_wr(TCC_OFF_CFG_HI, {22'h0, 2'(d), 6'h0, 2'(d)});
            for (int i = 0; i < 64; i++) begin
                p = 6'(i);
                @(posedge mclk_i);
                pin_req  <= p[4:0];
                trig_int <= p[5];
                repeat (4) @(posedge mclk_i);
                #1;
                check({28'h0, capture_input_o}, {28'h0, route_exp(2'(d), p)}, "routing");
                check({28'h0, channel_is_input_o}, (d != 0) ? 32'h0000_000F : 32'h0, "direction");
            end
            reg_chk(TCC_OFF_STATUS, {24'h0, (d != 0) ? 4'hF : 4'h0, route_exp(2'(d), p)});
        end
    endtask : test_routing

    task automatic test_lock();
        reg_wr(TCC_OFF_ENABLE, 32'h0);
        reg_wr(TCC_OFF_CFG_LO, 32'h0000_0101);
        reg_wr(TCC_OFF_ENABLE, 32'h0000_000F);
        reg_wr(TCC_OFF_CFG_LO, 32'h0000_FEFE);
        reg_chk(TCC_OFF_CFG_LO, 32'h0000_FDFD);
        reg_wr(TCC_OFF_ENABLE, 32'h0);
        reg_wr(TCC_OFF_CFG_LO, 32'h0000_FEFE);
        reg_chk(TCC_OFF_CFG_LO, 32'h0000_FEFE);
        reg_wr(TCC_OFF_CFG_LO, 32'h0);
    endtask : test_lock

    task automatic test_prescale();
        lag     <= 4'h5;
        // Pins start low so the first pulse gives a real rising edge
        pin_req <= 5'h00;
        for (int p = 0; p < 4; p++) begin
            reg_wr(TCC_OFF_ENABLE, 32'h0);
            reg_wr(TCC_OFF_CFG_LO, {20'h0, 2'(3 - p), 2'h1, 4'h0, 2'(p), 2'h1});
            reg_wr(TCC_OFF_CFG_HI, {20'h0, 2'(3 - p), 2'h2, 4'h0, 2'(p), 2'h1});
            reg_wr(TCC_OFF_ENABLE, 32'h0000_000F);
            ev1_cnt  = 0;
            ev2_cnt  = 0;
            ev3_cnt  = 0;
            ev4_cnt  = 0;
            counting = 1'b1;
            repeat (16) begin
                pin_req <= 5'h05;
                repeat (3) @(posedge mclk_i);
                pin_req <= 5'h00;
                repeat (3) @(posedge mclk_i);
            end
            repeat (12) @(posedge mclk_i);
            counting = 1'b0;
            check(32'(ev1_cnt), 32'(16 >> p), "ch1 captures");
            check(32'(ev2_cnt), 32'(16 >> (3 - p)), "ch2 captures");
            check(32'(ev3_cnt), 32'(16 >> p), "ch3 captures");
            check(32'(ev4_cnt), 32'(16 >> (3 - p)), "ch4 captures");
        end
        reg_wr(TCC_OFF_ENABLE, 32'h0);
        lag <= 4'h0;
    endtask : test_prescale

    task automatic wait_lvl(input logic v, input int lo, input int hi);
        int cnt;
        cnt = 0;
        do begin
            @(posedge mclk_i);
            #1;
            cnt++;
        end while (capture_input_o[0] !== v && cnt < hi);
        check({31'h0, capture_input_o[0]}, {31'h0, v}, "filter level late");
        check({31'h0, cnt >= lo}, 32'h1, "filter level early");
    endtask : wait_lvl

    task automatic test_filter();
        int n;
        int dv;
        for (int c = 0; c < 16; c++) begin
            n  = N_TAB[c];
            dv = DIV_TAB[c];
            reg_wr(TCC_OFF_CFG_LO, {24'h0, 4'(c), 4'h1});
            if (c != 0) begin
                // One low sample between two short pulses must restart the count
                watch_low = 1'b1;
                pin_req[0] <= 1'b1;
                repeat ((n - 1) * dv) @(posedge mclk_i);
                pin_req[0] <= 1'b0;
                repeat (dv) @(posedge mclk_i);
                pin_req[0] <= 1'b1;
                repeat ((n - 1) * dv) @(posedge mclk_i);
                pin_req[0] <= 1'b0;
                repeat (dv + 4) @(posedge mclk_i);
                watch_low = 1'b0;
                samples_checked++;
            end
            @(posedge mclk_i);
            pin_req[0] <= 1'b1;
            wait_lvl(1'b1, (n - 1) * dv, n * dv + dv + 4);
            @(posedge mclk_i);
            pin_req[0] <= 1'b0;
            wait_lvl(1'b0, (n - 1) * dv, n * dv + dv + 4);
        end
    endtask : test_filter

    initial begin
        resetn_i        = 1'b0;
        addr_i          = 8'h00;
        wdata_i         = 32'h0;
        wr_i            = 1'b0;
        rd_i            = 1'b0;
        pin_req         = 5'h00;
        lag             = 4'h0;
        trig_int        = 1'b0;
        err_total       = 0;
        samples_checked = 0;
        cycle_cnt       = 0;
        counting        = 1'b0;
        watch_low       = 1'b0;
        repeat (5) @(posedge mclk_i);
        resetn_i <= 1'b1;
        test_reset();
        test_routing();
        test_lock();
        test_prescale();
        test_filter();
        end_sim();
    end
endmodule : timer_capture_channel_config_bench
